//--- opcr_pkg.sv
/*
 Constants for the offset and power configuration register bank.
 Assumes: 5-bit register addresses, 8-bit register data.
*/
package opcr_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [4:0] OFFS_A_LOW = 5'h14;
    localparam logic [4:0] OFFS_B_LOW = 5'h15;
    localparam logic [4:0] OFFS_A_HIGH = 5'h16;
    localparam logic [4:0] OFFS_B_HIGH_PORT = 5'h17;
    localparam logic [4:0] OFFS_POWER_SLEEP = 5'h18;
    localparam logic [4:0] OFFS_REF_SELECT = 5'h19;
    localparam logic [4:0] OFFS_FACTORY = 5'h1a;
    // ==========================================================
    // Field positions
    localparam int HIGH_FIELD_MSB = 7;
    localparam int HIGH_FIELD_LSB = 3;
    localparam int FOUR_PIN_BIT = 2;
    localparam int CLKPATH_A_BIT = 1;
    localparam int CLKPATH_B_BIT = 0;
    localparam int TSENSE_BIT = 7;
    localparam int CLKRECV_BIT = 6;
    localparam int SLEEP_B_BIT = 3;
    localparam int SLEEP_A_BIT = 2;
    localparam int EXTREF_BIT = 2;
    // Stored bits of the power register; the rest read as zero
    localparam logic [7:0] POWER_STORED_MASK = 8'hcf;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_OFFS_A_LOW = 8'h00;
    localparam logic [7:0] RST_OFFS_B_LOW = 8'h00;
    localparam logic [7:0] RST_OFFS_A_HIGH = 8'h00;
    localparam logic [7:0] RST_OFFS_B_HIGH_PORT = 8'h00;
    localparam logic [7:0] RST_POWER_SLEEP = 8'h83;
    localparam logic [7:0] RST_REF_SELECT = 8'h00;
    localparam logic [7:0] RST_FACTORY = 8'h00;
    localparam logic [12:0] RST_OFFSET_WORD = 13'h0000;
endpackage : opcr_pkg

//--- opcr_offset_sync.sv
/*
 Applied offset words for both channels, loaded together on a sync pulse.
 Assumes: staged words and the pulse come from logic on ref_clk.
*/
`timescale 1ns/1ps
module opcr_offset_sync
    import opcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic syncPulse,
    input wire logic [12:0] stagedA,
    input wire logic [12:0] stagedB,
    output logic [12:0] appliedA_q,
    output logic [12:0] appliedB_q
);
    // ==========================================================
    // Both words move on the same edge
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            appliedA_q <= RST_OFFSET_WORD;
            appliedB_q <= RST_OFFSET_WORD;
        end
        else if (syncPulse)
        begin
            appliedA_q <= stagedA;
            appliedB_q <= stagedB;
        end
    end
endmodule : opcr_offset_sync

//--- opcr_regs.sv
/*
 Offset correction and power configuration register bank, with port
 direction steering for the serial data and alarm pins.
 Assumes: register access strobes, read data bits and the alarm level come
 from logic on ref_clk; the serial protocol decoder lives elsewhere.
*/
// Behaviour
// - Channel A offset is 13 bits: low byte plus upper five bits.
// - Channel B offset is 13 bits; upper bits sit in 0x17 bits 7:3.
// - Writing the channel A low byte syncs all four offset registers at once.
// - Other offset writes only store; the applied offset waits for a sync.
// - Bit 2 of 0x17 makes the port four-pin; alarm pin outputs read data.
// - Bit 1 of 0x17 sleeps the channel A clock path.
// - Bit 0 of 0x17 sleeps the channel B clock path.
// - Bit 7 of 0x18 enables the temperature sensor; on after reset.
// - Bit 6 of 0x18 sleeps clock receiver and sync strobe receiver.
// - Bit 3 of 0x18 sleeps channel B; resets to zero.
// - Bit 2 of 0x18 sleeps channel A; resets to zero.
// - Bit 2 of 0x19 selects reference: 0 internal, 1 external.
// - Four-pin mode: data pin only receives; three-pin: data pin both ways.
`timescale 1ns/1ps
module opcr_regs
    import opcr_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [4:0] regAddr,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData_q,
    output logic regRdHit_q,
    output logic [12:0] offsetA_q,
    output logic [12:0] offsetB_q,
    output logic fourPinPortSelect_q,
    output logic clkPathSleepA_q,
    output logic clkPathSleepB_q,
    output logic tempSensorEnable_q,
    output logic clkRecvSleep_q,
    output logic syncStrobeRecvSleep_q,
    output logic channelSleepB_q,
    output logic channelSleepA_q,
    output logic extRefSelect_q,
    input wire logic readDataBit,
    input wire logic readDriveActive,
    input wire logic alarmLevel,
    output logic sdioOut_q,
    output logic sdioOe_q,
    output logic alarmOrReadDataOut_q,
    output logic alarmOrReadDataOe_q
);
    // ==========================================================
    // Storage
    logic [7:0] offALow_q;
    logic [7:0] offBLow_q;
    logic [4:0] offAHigh_q;
    logic [7:0] offBHighPort_q;
    logic [7:0] power_q;
    logic extRef_q;
    logic [7:0] factory_q;
    logic syncPulse_q;
    logic [7:0] rdData_d;
    logic rdHit_d;

    function automatic logic writeTo(input logic [4:0] offs);
        writeTo = regWrEn && (regAddr == offs);
    endfunction : writeTo

    // ==========================================================
    // Offset staging registers; only the channel A low byte fires a sync
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            offALow_q <= RST_OFFS_A_LOW;
            offBLow_q <= RST_OFFS_B_LOW;
            offAHigh_q <= RST_OFFS_A_HIGH[HIGH_FIELD_MSB:HIGH_FIELD_LSB];
            offBHighPort_q <= RST_OFFS_B_HIGH_PORT;
            syncPulse_q <= 1'b0;
        end
        else
        begin
            if (writeTo(OFFS_A_LOW))
                offALow_q <= regWrData;
            if (writeTo(OFFS_B_LOW))
                offBLow_q <= regWrData;
            if (writeTo(OFFS_A_HIGH))
                offAHigh_q <= regWrData[HIGH_FIELD_MSB:HIGH_FIELD_LSB];
            if (writeTo(OFFS_B_HIGH_PORT))
                offBHighPort_q <= regWrData;
            syncPulse_q <= writeTo(OFFS_A_LOW);
        end
    end

    opcr_offset_sync uOffsetSync (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .syncPulse(syncPulse_q),
        .stagedA({offAHigh_q, offALow_q}),
        .stagedB({offBHighPort_q[HIGH_FIELD_MSB:HIGH_FIELD_LSB], offBLow_q}),
        .appliedA_q(offsetA_q),
        .appliedB_q(offsetB_q)
    );

    // ==========================================================
    // Power, reference and factory registers
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            power_q <= RST_POWER_SLEEP;
            extRef_q <= RST_REF_SELECT[EXTREF_BIT];
            factory_q <= RST_FACTORY;
        end
        else
        begin
            if (writeTo(OFFS_POWER_SLEEP))
                power_q <= regWrData & POWER_STORED_MASK;
            if (writeTo(OFFS_REF_SELECT))
                extRef_q <= regWrData[EXTREF_BIT];
            if (writeTo(OFFS_FACTORY))
                factory_q <= regWrData;
        end
    end

    // ==========================================================
    // Control outputs, one flop each, loaded with their register bit
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            fourPinPortSelect_q <= RST_OFFS_B_HIGH_PORT[FOUR_PIN_BIT];
            clkPathSleepA_q <= RST_OFFS_B_HIGH_PORT[CLKPATH_A_BIT];
            clkPathSleepB_q <= RST_OFFS_B_HIGH_PORT[CLKPATH_B_BIT];
            tempSensorEnable_q <= RST_POWER_SLEEP[TSENSE_BIT];
            clkRecvSleep_q <= RST_POWER_SLEEP[CLKRECV_BIT];
            syncStrobeRecvSleep_q <= RST_POWER_SLEEP[CLKRECV_BIT];
            channelSleepB_q <= RST_POWER_SLEEP[SLEEP_B_BIT];
            channelSleepA_q <= RST_POWER_SLEEP[SLEEP_A_BIT];
            extRefSelect_q <= RST_REF_SELECT[EXTREF_BIT];
        end
        else
        begin
            fourPinPortSelect_q <= offBHighPort_q[FOUR_PIN_BIT];
            clkPathSleepA_q <= offBHighPort_q[CLKPATH_A_BIT];
            clkPathSleepB_q <= offBHighPort_q[CLKPATH_B_BIT];
            tempSensorEnable_q <= power_q[TSENSE_BIT];
            clkRecvSleep_q <= power_q[CLKRECV_BIT];
            syncStrobeRecvSleep_q <= power_q[CLKRECV_BIT];
            channelSleepB_q <= power_q[SLEEP_B_BIT];
            channelSleepA_q <= power_q[SLEEP_A_BIT];
            extRefSelect_q <= extRef_q;
        end
    end

    // ==========================================================
    // Pin steering: four-pin mode moves read data to the alarm pin
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            sdioOut_q <= 1'b0;
            sdioOe_q <= 1'b0;
            alarmOrReadDataOut_q <= 1'b0;
            alarmOrReadDataOe_q <= 1'b0;
        end
        else
        begin
            alarmOrReadDataOe_q <= 1'b1;
            if (offBHighPort_q[FOUR_PIN_BIT])
            begin
                sdioOut_q <= 1'b0;
                sdioOe_q <= 1'b0;
                alarmOrReadDataOut_q <= readDataBit;
            end
            else
            begin
                sdioOut_q <= readDataBit;
                sdioOe_q <= readDriveActive;
                alarmOrReadDataOut_q <= alarmLevel;
            end
        end
    end

    // ==========================================================
    // Read path: answer one cycle after the strobe
    always_comb
    begin
        rdData_d = 8'h00;
        rdHit_d = 1'b1;
        unique case (regAddr)
            OFFS_A_LOW: rdData_d = offALow_q;
            OFFS_B_LOW: rdData_d = offBLow_q;
            OFFS_A_HIGH: rdData_d = {offAHigh_q, 3'h0};
            OFFS_B_HIGH_PORT: rdData_d = offBHighPort_q;
            OFFS_POWER_SLEEP: rdData_d = power_q;
            OFFS_REF_SELECT: rdData_d = {5'h00, extRef_q, 2'h0};
            OFFS_FACTORY: rdData_d = factory_q;
            default: rdHit_d = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            regRdData_q <= 8'h00;
            regRdHit_q <= 1'b0;
        end
        else if (regRdEn)
        begin
            regRdData_q <= rdData_d;
            regRdHit_q <= rdHit_d;
        end
    end

    // ==========================================================
    // Checks
    sequence sAWrite;
        regWrEn && regAddr == OFFS_A_LOW;
    endsequence
    // Compare against the staged words seen at the pulse edge, since a
    // back-to-back write may already have moved the staging registers
    sequence sSyncFires;
        syncPulse_q ##1 (offsetA_q == $past({offAHigh_q, offALow_q})
            && offsetB_q == $past(
                {offBHighPort_q[HIGH_FIELD_MSB:HIGH_FIELD_LSB], offBLow_q}));
    endsequence

    a_sync_loads_both: assert property (@(posedge ref_clk) disable iff (!rst_b)
        sAWrite |=> sSyncFires)
        else $error("offset sync did not load both words");
    a_offset_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !syncPulse_q |=> $stable(offsetA_q) && $stable(offsetB_q))
        else $error("applied offset changed without sync");
    a_other_no_sync: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regWrEn && regAddr != OFFS_A_LOW |=> !syncPulse_q)
        else $error("sync fired on a non-trigger write");
    a_four_pin_sel: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regWrEn && regAddr == OFFS_B_HIGH_PORT |=> ##1
        fourPinPortSelect_q == $past(regWrData[FOUR_PIN_BIT], 2))
        else $error("four-pin select wrong");
    a_clkpath_sleep: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regWrEn && regAddr == OFFS_B_HIGH_PORT |=> ##1
        clkPathSleepA_q == $past(regWrData[CLKPATH_A_BIT], 2)
        && clkPathSleepB_q == $past(regWrData[CLKPATH_B_BIT], 2))
        else $error("clock path sleep wrong");
    a_tsense_reset: assert property (@(posedge ref_clk)
        $rose(rst_b) |-> tempSensorEnable_q && !channelSleepA_q)
        else $error("reset values of power outputs wrong");
    a_recv_sleep: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regWrEn && regAddr == OFFS_POWER_SLEEP |=> ##1
        clkRecvSleep_q == $past(regWrData[CLKRECV_BIT], 2)
        && syncStrobeRecvSleep_q == clkRecvSleep_q)
        else $error("receiver sleep wrong");
    a_chan_sleep: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regWrEn && regAddr == OFFS_POWER_SLEEP |=> ##1
        tempSensorEnable_q == $past(regWrData[TSENSE_BIT], 2)
        && channelSleepB_q == $past(regWrData[SLEEP_B_BIT], 2)
        && channelSleepA_q == $past(regWrData[SLEEP_A_BIT], 2))
        else $error("channel sleep wrong");
    a_ref_select: assert property (@(posedge ref_clk) disable iff (!rst_b)
        regWrEn && regAddr == OFFS_REF_SELECT |=> ##1
        extRefSelect_q == $past(regWrData[EXTREF_BIT], 2))
        else $error("reference select wrong");
    a_pin_direction: assert property (@(posedge ref_clk) disable iff (!rst_b)
        offBHighPort_q[FOUR_PIN_BIT] |=> !sdioOe_q && alarmOrReadDataOe_q)
        else $error("four-pin data pin driven");
endmodule : opcr_regs

//--- opcr_regs_bench.sv
/*
 Self-checking bench for the offset and power configuration register bank.
 Assumes: opcr_regs and opcr_pkg compiled first; one 100 MHz clock.
*/
`timescale 1ns/1ps
`define CHECK(nm, exp, got) \
    begin \
        samplesChecked++; \
        if ((got) !== (exp)) \
        begin \
            badCount++; \
            $display("wrong value %s expected %h seen %h", nm, exp, got); \
        end \
    end
module opcr_regs_bench
    import opcr_pkg::*;
;
    // ==========================================================
    // Stimulus and observed signals
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic regWrEn = 1'b0;
    logic regRdEn = 1'b0;
    logic [4:0] regAddr = 5'h00;
    logic [7:0] regWrData = 8'h00;
    logic readDataBit = 1'b0;
    logic readDriveActive = 1'b0;
    logic alarmLevel = 1'b0;
    logic [7:0] regRdData_q;
    logic regRdHit_q, fourPinPortSelect_q, clkPathSleepA_q, clkPathSleepB_q;
    logic tempSensorEnable_q, clkRecvSleep_q, syncStrobeRecvSleep_q;
    logic channelSleepB_q, channelSleepA_q, extRefSelect_q;
    logic sdioOut_q, sdioOe_q, alarmOrReadDataOut_q, alarmOrReadDataOe_q;
    logic [12:0] offsetA_q, offsetB_q;
    logic [8:0] ctl;
    int badCount = 0;
    int samplesChecked = 0;
    logic [7:0] rstVal [7] = '{RST_OFFS_A_LOW, RST_OFFS_B_LOW, RST_OFFS_A_HIGH,
        RST_OFFS_B_HIGH_PORT, RST_POWER_SLEEP, RST_REF_SELECT, RST_FACTORY};
    logic [7:0] pwrWr [6] = '{8'h03, 8'h43, 8'h0b, 8'h07, 8'hf3, 8'h83};
    logic [7:0] pwrRd [6] = '{8'h03, 8'h43, 8'h0b, 8'h07, 8'hc3, 8'h83};
    assign ctl = {fourPinPortSelect_q, clkPathSleepA_q, clkPathSleepB_q,
        tempSensorEnable_q, clkRecvSleep_q, syncStrobeRecvSleep_q,
        channelSleepB_q, channelSleepA_q, extRefSelect_q};
    always #5 ref_clk = ~ref_clk;
    opcr_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .regWrEn(regWrEn),
        .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData_q(regRdData_q), .regRdHit_q(regRdHit_q),
        .offsetA_q(offsetA_q), .offsetB_q(offsetB_q),
        .fourPinPortSelect_q(fourPinPortSelect_q),
        .clkPathSleepA_q(clkPathSleepA_q), .clkPathSleepB_q(clkPathSleepB_q),
        .tempSensorEnable_q(tempSensorEnable_q),
        .clkRecvSleep_q(clkRecvSleep_q),
        .syncStrobeRecvSleep_q(syncStrobeRecvSleep_q),
        .channelSleepB_q(channelSleepB_q), .channelSleepA_q(channelSleepA_q),
        .extRefSelect_q(extRefSelect_q), .readDataBit(readDataBit),
        .readDriveActive(readDriveActive), .alarmLevel(alarmLevel),
        .sdioOut_q(sdioOut_q), .sdioOe_q(sdioOe_q),
        .alarmOrReadDataOut_q(alarmOrReadDataOut_q),
        .alarmOrReadDataOe_q(alarmOrReadDataOe_q));
    // ==========================================================
    // Access tasks
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        regWrEn = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge ref_clk);
        regWrEn = 1'b0;
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] d,
        input logic h);
        @(negedge ref_clk);
        regRdEn = 1'b1;
        regAddr = a;
        @(negedge ref_clk);
        regRdEn = 1'b0;
        `CHECK("read data", d, regRdData_q)
        `CHECK("read hit", h, regRdHit_q)
    endtask : rd
    // Two edges: the control outputs or the sync load, then one spare
    task automatic settle;
        repeat (2) @(negedge ref_clk);
    endtask : settle
    // Pin stimulus {data, drive, alarm}; expect {out, oe, alarm out, alarm oe}
    task automatic pin(input logic [2:0] s, input logic [3:0] e);
        @(negedge ref_clk);
        {readDataBit, readDriveActive, alarmLevel} = s;
        @(negedge ref_clk);
        `CHECK("pin enables", e[2:0],
            {sdioOe_q, alarmOrReadDataOut_q, alarmOrReadDataOe_q})
        if (e[2])
            `CHECK("data pin", e[3], sdioOut_q)
    endtask : pin
    task automatic finish_test;
        if (badCount == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // ==========================================================
    // Watchdog
    initial
    begin
        #100us;
        badCount++;
        finish_test();
    end
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (20) @(negedge ref_clk);
        `CHECK("alarm oe in reset", 1'b0, alarmOrReadDataOe_q)
        `CHECK("controls in reset", 9'h020, ctl)
        rst_b = 1'b1;
        for (int i = 0; i < 7; i++)
            rd(OFFS_A_LOW + 5'(i), rstVal[i], 1'b1);
        rd(5'h13, 8'h00, 1'b0);
        rd(5'h1b, 8'h00, 1'b0);
        wr(5'h13, 8'hff);
        rd(5'h13, 8'h00, 1'b0);
        wr(OFFS_FACTORY, 8'ha5);
        rd(OFFS_FACTORY, 8'ha5, 1'b1);
        // Staged offsets must not reach the outputs before the sync
        wr(OFFS_B_LOW, 8'h5a);
        wr(OFFS_A_HIGH, 8'hff);
        wr(OFFS_B_HIGH_PORT, 8'ha8);
        settle();
        `CHECK("offset a staged", 13'h0000, offsetA_q)
        `CHECK("offset b staged", 13'h0000, offsetB_q)
        rd(OFFS_A_HIGH, 8'hf8, 1'b1);
        wr(OFFS_A_LOW, 8'h3c);
        settle();
        `CHECK("offset a", 13'h1f3c, offsetA_q)
        `CHECK("offset b", 13'h155a, offsetB_q)
        wr(OFFS_B_LOW, 8'h11);
        settle();
        `CHECK("offset b held", 13'h155a, offsetB_q)
        for (int b = 0; b < 3; b++)
        begin
            wr(OFFS_B_HIGH_PORT, 8'ha8 | (8'h01 << b));
            settle();
            `CHECK("port and clock path", 3'(1 << b), ctl[8:6])
            `CHECK("offset b no sync", 13'h155a, offsetB_q)
        end
        wr(OFFS_A_LOW, 8'h00);
        settle();
        `CHECK("offset b resync", 13'h1511, offsetB_q)
        `CHECK("offset a resync", 13'h1f00, offsetA_q)
        // Four-pin mode is still on from the last loop pass
        pin(3'b101, 4'b0011);
        pin(3'b010, 4'b0001);
        pin(3'b110, 4'b0011);
        wr(OFFS_B_HIGH_PORT, 8'ha8);
        settle();
        pin(3'b110, 4'b1101);
        pin(3'b001, 4'b0011);
        pin(3'b010, 4'b0101);
        for (int i = 0; i < 6; i++)
        begin
            wr(OFFS_POWER_SLEEP, pwrWr[i]);
            settle();
            rd(OFFS_POWER_SLEEP, pwrRd[i], 1'b1);
            `CHECK("power controls", {pwrRd[i][7], pwrRd[i][6], pwrRd[i][6],
                pwrRd[i][3], pwrRd[i][2]}, ctl[5:1])
        end
        wr(OFFS_REF_SELECT, 8'hff);
        settle();
        rd(OFFS_REF_SELECT, 8'h04, 1'b1);
        `CHECK("external reference", 1'b1, extRefSelect_q)
        wr(OFFS_REF_SELECT, 8'h00);
        settle();
        `CHECK("internal reference", 1'b0, extRefSelect_q)
        // Second reset in mid-run
        wr(OFFS_POWER_SLEEP, 8'h4f);
        @(negedge ref_clk);
        rst_b = 1'b0;
        @(negedge ref_clk);
        `CHECK("controls after reset", 9'h020, ctl)
        `CHECK("offset a after reset", 13'h0000, offsetA_q)
        `CHECK("alarm oe mid reset", 1'b0, alarmOrReadDataOe_q)
        rst_b = 1'b1;
        rd(OFFS_POWER_SLEEP, 8'h83, 1'b1);
        rd(OFFS_A_HIGH, 8'h00, 1'b1);
        finish_test();
    end
endmodule : opcr_regs_bench
